// *** common/rtseq_pkg.sv ***
/*
  Shared constants for the reset and time-out sequencer: register map,
  field positions, reset values, timing counts, oscillator modes and states.
  Assumes a 200 MHz core clock and a nominal internal slow oscillator period.
*/
package rtseq_pkg;

  // Core clock and timing figures
  localparam int unsigned CLK_PERIOD_PS       = 5000;
  localparam int unsigned PWRUP_DELAY_MS      = 72;
  localparam int unsigned SLOW_OSC_PERIOD_NS  = 1000;
  localparam int unsigned PWRUP_DELAY_TICKS   = PWRUP_DELAY_MS * 1000000 / SLOW_OSC_PERIOD_NS;
  localparam int unsigned SETTLE_EDGES        = 1024;
  localparam int unsigned BROWNOUT_MIN_US     = 100;
  // Least time: round up to whole cycles
  localparam int unsigned BROWNOUT_MIN_CYCLES =
    (BROWNOUT_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLEAR_FILTER_NS     = 20;
  localparam int unsigned CLEAR_FILTER_CYCLES =
    (CLEAR_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register byte offsets
  localparam logic [3:0] OFS_POWER_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONFIG       = 4'h4;
  localparam logic [3:0] OFS_STATUS       = 4'h8;

  // Field positions
  localparam int unsigned PS_BROWNOUT_N_BIT = 0;
  localparam int unsigned PS_POWERON_N_BIT  = 1;
  localparam int unsigned CFG_DELAY_N_BIT   = 0;
  localparam int unsigned CFG_BOD_EN_BIT    = 1;
  localparam int unsigned CFG_MODE_LSB      = 2;

  // Reset values
  localparam logic [1:0] PS_RESET       = 2'h0;
  localparam logic       CFG_DELAY_N_RST = 1'h0;
  localparam logic       CFG_BOD_EN_RST  = 1'h0;
  localparam logic [2:0] PAGE_RESET      = 3'h0;
  localparam logic [12:0] PC_RESET_VEC   = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC     = 13'h0004;

  typedef enum logic [1:0] {
    MODE_LOW_POWER_CRYSTAL,
    MODE_MID_CRYSTAL,
    MODE_HIGH_SPEED_CRYSTAL,
    MODE_RESISTOR_CAP
  } rtseq_osc_mode_t;

  localparam rtseq_osc_mode_t CFG_MODE_RST = MODE_MID_CRYSTAL;

  typedef enum logic [2:0] {
    ST_DELAY,
    ST_SETTLE,
    ST_BROWNOUT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } rtseq_state_t;

endpackage : rtseq_pkg

// *** sim/rtseq_partner.sv ***
/*
  Far-side model: slow oscillator, oscillator pin, supply detector, master clear.
  Assumes the bench raises lowReq and clearReq right after a clock edge.
*/
`timescale 1ns/1ps
module rtseq_partner #(
  parameter int unsigned SLOW_HALF_NS = 30,
  parameter int unsigned OSC_HALF_NS  = 20
) (
  input  wire logic ref_clk,
  input  wire logic lowReq,
  input  wire logic clearReq,
  output logic      slowOscIn,
  output logic      oscInputPin,
  output logic      supplyLow,
  output logic      masterClearPinN
);
  // Both oscillators run free; half periods avoid the rising clock edges
  initial begin
    slowOscIn = 1'b0;
    oscInputPin = 1'b0;
    supplyLow = 1'b0;
    masterClearPinN = 1'b1;
  end
  always #(SLOW_HALF_NS) slowOscIn = ~slowOscIn;
  always #(OSC_HALF_NS) oscInputPin = ~oscInputPin;
  // Detector and pin follow requests one edge late, like a slow board
  always @(posedge ref_clk) begin
    supplyLow <= lowReq;
    masterClearPinN <= ~clearReq;
  end
endmodule : rtseq_partner

// *** sim/rtseq_sequencer_tb.sv ***
/*
  Self-checking bench for the reset sequencer: Avalon master, queued checks.
  Assumes the shortened counts below and the partner's oscillator rates.
*/
`timescale 1ns/1ps
module rtseq_sequencer_tb;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        lowReq = 1'b0, clearReq = 1'b0;
  logic        slowOscIn, oscInputPin, supplyLow, masterClearPinN;
  logic        watchdogTimeout = 1'b0, sleepEnter = 1'b0, clearWatchdog = 1'b0;
  logic        wakeIrq = 1'b0, globalIrqEnable = 1'b0;
  logic [3:0]  address = 4'h0, byteenable = 4'h0;
  logic        read = 1'b0, write = 1'b0;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, coreResetN, coreRun, pcLoad, pcAdvance;
  logic [12:0] pcValue;
  logic [4:0]  statusUpper;
  logic [31:0] rdQ[$];
  logic [14:0] pcQ[$];
  int          bad_count = 0, n_compared = 0, cycles = 0, dur;
  time         t0;

  always #2.5 ref_clk = ~ref_clk;

  rtseq_partner i_rtseq_partner (.ref_clk(ref_clk), .lowReq(lowReq), .clearReq(clearReq),
    .slowOscIn(slowOscIn), .oscInputPin(oscInputPin), .supplyLow(supplyLow),
    .masterClearPinN(masterClearPinN));

  rtseq_sequencer #(.DELAY_TICKS(8), .BROWNOUT_CYCLES(16), .SETTLE_COUNT(8), .CLEAR_CYCLES(4))
  i_rtseq_sequencer (.ref_clk(ref_clk), .arst_n(arst_n), .slowOscIn(slowOscIn),
    .oscInputPin(oscInputPin), .supplyLow(supplyLow), .masterClearPinN(masterClearPinN),
    .watchdogTimeout(watchdogTimeout), .sleepEnter(sleepEnter), .clearWatchdog(clearWatchdog),
    .wakeIrq(wakeIrq), .globalIrqEnable(globalIrqEnable), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .coreResetN(coreResetN), .coreRun(coreRun), .pcLoad(pcLoad),
    .pcValue(pcValue), .pcAdvance(pcAdvance), .statusUpper(statusUpper));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Hang guard well above the whole sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // Result watcher: oldest note against each answer
  always @(posedge ref_clk) begin
    if (read && waitrequest === 1'b0) chk("readdata", rdQ.size() ? rdQ.pop_front() : 32'hdead, readdata);
    if (pcLoad === 1'b1 || pcAdvance === 1'b1)
      chk("pc event", pcQ.size() ? pcQ.pop_front() : 15'h7fff,
          {pcAdvance, pcLoad, pcAdvance ? 13'h0 : pcValue});
  end

  // Request held until waitrequest is seen low at an edge
  task busCyc(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= rd;
    write <= ~rd;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : busCyc

  task busRd(input logic [3:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    busCyc(1'b1, a, 32'h0, 4'hf);
  endtask : busRd

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task pulseIn(input int k);
    @(posedge ref_clk);
    if (k == 0) sleepEnter <= 1'b1;
    else if (k == 1) watchdogTimeout <= 1'b1;
    else clearWatchdog <= 1'b1;
    @(posedge ref_clk);
    sleepEnter <= 1'b0;
    watchdogTimeout <= 1'b0;
    clearWatchdog <= 1'b0;
  endtask : pulseIn

  task waitRst(input int lim);
    for (int n = 0; n < lim && coreResetN !== 1'b1; n++) @(posedge ref_clk);
    dur = int'(($time - t0) / 5);
  endtask : waitRst

  task waitPc;
    for (int n = 0; n < 300 && pcQ.size() > 0; n++) @(posedge ref_clk);
    chk("pending pc events", 0, pcQ.size());
  endtask : waitPc

  initial begin
    void'($urandom(99204));
    // Power-on: reset values, then delay plus settle
    pcQ.push_back(15'h2000);
    tick(4);
    arst_n <= 1'b1;
    t0 = $time;
    // Sleep, watchdog and wake inputs must be ignored while the delay runs
    {wakeIrq, globalIrqEnable, clearWatchdog, sleepEnter, watchdogTimeout} <= 5'($urandom());
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h0);
    busRd(rtseq_pkg::OFS_CONFIG, 32'h4);
    busRd(rtseq_pkg::OFS_STATUS, 32'h3);
    busRd(4'hc, 32'h0);
    {wakeIrq, globalIrqEnable, clearWatchdog, sleepEnter, watchdogTimeout} <= 5'h0;
    chk("coreResetN", 1'b0, coreResetN);
    waitRst(400);
    chk("por hold in range", 1, dur >= 140 && dur <= 190);
    chk("coreRun", 1'b1, coreRun);
    waitPc();
    $display("test power_on done");
    // Status flags: software sets, partial and read-only writes ignored
    busCyc(1'b0, rtseq_pkg::OFS_POWER_STATUS, ($urandom() & 32'hffffff00) | 32'h3, 4'hf);
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h3);
    busCyc(1'b0, rtseq_pkg::OFS_POWER_STATUS, 32'h0, 4'he);
    busCyc(1'b0, rtseq_pkg::OFS_STATUS, 32'h1f, 4'hf);
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h3);
    busRd(rtseq_pkg::OFS_STATUS, 32'h3);
    $display("test registers done");
    // Brown-out in resistor-cap mode with delay bit set: forced delay, restart on new dip
    busCyc(1'b0, rtseq_pkg::OFS_CONFIG, 32'h0f, 4'h1);
    busRd(rtseq_pkg::OFS_CONFIG, 32'h0f);
    lowReq <= 1'b1;
    tick(4 + $urandom() % 6);
    lowReq <= 1'b0;
    tick(12);
    chk("coreResetN short dip", 1'b1, coreResetN);
    lowReq <= 1'b1;
    tick(40);
    chk("coreResetN long dip", 1'b0, coreResetN);
    tick(60);
    chk("coreResetN while low", 1'b0, coreResetN);
    lowReq <= 1'b0;
    tick(45);
    lowReq <= 1'b1;
    tick(40);
    chk("coreResetN redip", 1'b0, coreResetN);
    pcQ.push_back(15'h2000);
    lowReq <= 1'b0;
    t0 = $time;
    waitRst(300);
    chk("brownout hold in range", 1, dur >= 84 && dur <= 115);
    waitPc();
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h2);
    chk("statusUpper brownout", 5'h03, statusUpper);
    $display("test brownout done");
    // Sleep in high-speed crystal mode, so both wake-ups run the settle count
    busCyc(1'b0, rtseq_pkg::OFS_CONFIG, 32'h0a, 4'h1);
    pulseIn(0);
    tick(5);
    chk("coreRun sleep", 1'b0, coreRun);
    chk("statusUpper sleep", 5'h02, statusUpper);
    globalIrqEnable <= 1'b1;
    pcQ.push_back(15'h2004);
    wakeIrq <= 1'b1;
    waitPc();
    wakeIrq <= 1'b0;
    chk("statusUpper irq wake", 5'h02, statusUpper);
    pulseIn(0);
    globalIrqEnable <= 1'b0;
    tick(5);
    pcQ.push_back(15'h4000);
    pulseIn(1);
    waitPc();
    chk("statusUpper watchdog wake", 5'h00, statusUpper);
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h2);
    pcQ.push_back(15'h2000);
    pulseIn(1);
    waitPc();
    chk("statusUpper watchdog reset", 5'h01, statusUpper);
    $display("test sleep_watchdog done");
    // Master clear: glitch ignored, held low then prompt release
    clearReq <= 1'b1;
    tick(2);
    clearReq <= 1'b0;
    tick(12);
    chk("coreResetN glitch", 1'b1, coreResetN);
    pcQ.push_back(15'h2000);
    clearReq <= 1'b1;
    tick(20);
    chk("coreResetN clear pin", 1'b0, coreResetN);
    chk("statusUpper clear pin", 5'h01, statusUpper);
    clearReq <= 1'b0;
    t0 = $time;
    waitRst(20);
    chk("clear pin release prompt", 1, dur <= 8);
    waitPc();
    pulseIn(2);
    tick(2);
    chk("statusUpper clear", 5'h03, statusUpper);
    $display("test master_clear done");
    // Second power-on; software switches the delay off early, settle only
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    t0 = $time;
    pcQ.push_back(15'h2000);
    busCyc(1'b0, rtseq_pkg::OFS_CONFIG, 32'h1, 4'h1);
    busRd(rtseq_pkg::OFS_POWER_STATUS, 32'h0);
    waitRst(200);
    chk("delay off hold in range", 1, dur >= 60 && dur <= 90);
    waitPc();
    $display("test delay_off done");
    end_sim();
  end
endmodule : rtseq_sequencer_tb

// *** src/rtseq_sequencer.sv ***
/*
  Reset and time-out sequencer with an Avalon-MM register slave.
  Assumes arst_n is the raw power-on indication, and that slow oscillator,
  oscillator pin, supply-low and master clear arrive asynchronously.
*/
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// RULE1 - After power-on, hold reset for a 72 ms slow-oscillator delay.
// RULE2 - Config bit low enables the power-up delay; high suppresses it.
// RULE3 - After the delay, count 1024 oscillator pin cycles before running.
// RULE4 - Settle count only in crystal modes, after power-on or sleep wake-up; the code also runs it after the brown-out delay.
// RULE5 - Crystal: delay plus settle; wake or no delay: settle only; resistor-cap: delay.
// RULE6 - With brown-out enabled, reset when supply-low outlasts about 100 us.
// RULE7 - After brown-out, hold until supply recovers, then one more delay.
// RULE8 - Supply-low during that delay restarts the brown-out process.
// RULE9 - Brown-out enabled forces the power-up delay on.
// RULE10 - Leave reset when the last applicable delay completes.
// RULE11 - Master clear held through the delays releases the core at once.
// RULE12 - Status bit 0 low-active brown-out flag, cleared by brown-out.
// RULE13 - Status bit 1 low-active power-on flag, cleared only by power-on.
// RULE14 - Timeout and sleep-entry flags set per reset or wake-up cause.
// RULE15 - Resets load address zero; wake-ups advance or take the vector.
// RULE16 - Power-on and brown-out load upper status 00011; pair per cause.
// RULE17 - Master clear is glitch filtered; watchdog never drives that pin.
// RULE18 - Watchdog wake-up resumes operation without resetting registers.
// RULE19 - Asynchronous sources are synchronised before they release reset.
// RULE20 - Counters and cause logic are cleared by the raw power-on reset.
module rtseq_sequencer #(
  parameter int unsigned DELAY_TICKS     = rtseq_pkg::PWRUP_DELAY_TICKS,
  parameter int unsigned BROWNOUT_CYCLES = rtseq_pkg::BROWNOUT_MIN_CYCLES,
  parameter int unsigned SETTLE_COUNT    = rtseq_pkg::SETTLE_EDGES,
  parameter int unsigned CLEAR_CYCLES    = rtseq_pkg::CLEAR_FILTER_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        slowOscIn,
  input  wire logic        oscInputPin,
  input  wire logic        supplyLow,
  input  wire logic        masterClearPinN,
  input  wire logic        watchdogTimeout,
  input  wire logic        sleepEnter,
  input  wire logic        clearWatchdog,
  input  wire logic        wakeIrq,
  input  wire logic        globalIrqEnable,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  output logic             coreResetN,
  output logic             coreRun,
  output logic             pcLoad,
  output logic      [12:0] pcValue,
  output logic             pcAdvance,
  output logic      [4:0]  statusUpper
);

  localparam int unsigned DW = $clog2(DELAY_TICKS + 1);
  localparam int unsigned SW = $clog2(SETTLE_COUNT + 1);
  localparam int unsigned BW = $clog2(BROWNOUT_CYCLES + 1);
  localparam int unsigned MW = $clog2(CLEAR_CYCLES + 1);

  typedef struct packed {
    rtseq_pkg::rtseq_state_t    st;
    logic [DW-1:0]              dlyCnt;
    logic [SW-1:0]              setCnt;
    logic [BW-1:0]              bodCnt;
    logic [MW-1:0]              mcfCnt;
    logic                       clrLow;
    logic                       slowPrev;
    logic                       oscPrev;
    logic                       wakeVec;
    logic                       timeoutFlag;
    logic                       sleepEntryFlag;
    logic [2:0]                 page;
    logic [1:0]                 pwrStatus;
    logic                       cfgDelayN;
    logic                       cfgBodEn;
    rtseq_pkg::rtseq_osc_mode_t cfgMode;
    logic                       coreResetN;
    logic                       coreRun;
    logic                       pcLoad;
    logic [12:0]                pcValue;
    logic                       pcAdvance;
    logic                       waitrequest;
    logic [31:0]                readdata;
  } rtseq_regs_t;

  // Power-on state; both flags high, both status bits cleared
  localparam rtseq_regs_t REG_RESET = '{
    st:             rtseq_pkg::ST_DELAY,
    timeoutFlag:    1'h1,
    sleepEntryFlag: 1'h1,
    page:           rtseq_pkg::PAGE_RESET,
    pwrStatus:      rtseq_pkg::PS_RESET,
    cfgDelayN:      rtseq_pkg::CFG_DELAY_N_RST,
    cfgBodEn:       rtseq_pkg::CFG_BOD_EN_RST,
    cfgMode:        rtseq_pkg::CFG_MODE_RST,
    waitrequest:    1'h1,
    pcValue:        rtseq_pkg::PC_RESET_VEC,
    default:        '0
  };

  rtseq_regs_t s;
  rtseq_regs_t next_s;
  logic [3:0]  syncIn;
  logic        slowSync;
  logic        oscSync;
  logic        supLow;
  logic        clrPinN;
  logic        slowTick;
  logic        oscEdge;
  logic        isCrystal;
  logic        delayOn;
  logic        accept;
  logic        dogRst;
  logic        bodTrip;
  logic        clrFall;
  logic        leaveDelay;
  logic        goRun;

  // All asynchronous sources pass two flops first
  rtseq_sync #(
    .WIDTH (4)
  ) i_rtseq_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .asyncIn ({masterClearPinN, supplyLow, oscInputPin, slowOscIn}),
    .syncOut (syncIn)
  ); // RULE19

  assign slowSync  = syncIn[0];
  assign oscSync   = syncIn[1];
  assign supLow    = syncIn[2];
  assign clrPinN   = syncIn[3];
  // Edges are taken from the stable stage only
  assign slowTick  = slowSync & ~s.slowPrev;
  assign oscEdge   = oscSync & ~s.oscPrev;
  assign isCrystal = (s.cfgMode != rtseq_pkg::MODE_RESISTOR_CAP);
  assign delayOn   = ~s.cfgDelayN | s.cfgBodEn; // RULE2 RULE9
  assign accept    = (read | write) & ~s.waitrequest;

  always_comb begin
    next_s      = s;
    dogRst      = 1'b0;
    bodTrip     = 1'b0;
    leaveDelay  = 1'b0;
    goRun       = 1'b0;
    next_s.pcLoad    = 1'b0;
    next_s.pcAdvance = 1'b0;
    next_s.slowPrev  = slowSync;
    next_s.oscPrev   = oscSync;

    // Master clear filter; release is immediate
    if (clrPinN) begin
      next_s.mcfCnt = '0;
      next_s.clrLow = 1'b0;
    end else if (s.mcfCnt != MW'(CLEAR_CYCLES - 1)) begin
      next_s.mcfCnt = s.mcfCnt + MW'(1); // RULE17
    end else begin
      next_s.clrLow = 1'b1;
    end
    clrFall = next_s.clrLow & ~s.clrLow;

    // Supply-low must outlast the minimum duration
    if (s.cfgBodEn && supLow) begin
      if (s.bodCnt != BW'(BROWNOUT_CYCLES - 1)) begin
        next_s.bodCnt = s.bodCnt + BW'(1);
      end else begin
        bodTrip = 1'b1; // RULE6
      end
    end else begin
      next_s.bodCnt = '0;
    end

    // One-wait-state slave; data latched as waitrequest drops
    next_s.waitrequest = 1'b1;
    if ((read || write) && s.waitrequest) begin
      next_s.waitrequest = 1'b0;
      unique case (address)
        rtseq_pkg::OFS_POWER_STATUS: next_s.readdata = {30'h0, s.pwrStatus};
        rtseq_pkg::OFS_CONFIG:
          next_s.readdata = {28'h0, s.cfgMode, s.cfgBodEn, s.cfgDelayN};
        rtseq_pkg::OFS_STATUS:
          next_s.readdata = {27'h0, s.page, s.timeoutFlag, s.sleepEntryFlag};
        default: next_s.readdata = 32'h0;
      endcase
    end
    // Writes land first so hardware events below win
    if (accept && write && byteenable[0]) begin
      if (address == rtseq_pkg::OFS_POWER_STATUS) begin
        next_s.pwrStatus = writedata[1:0]; // RULE12 RULE13
      end else if (address == rtseq_pkg::OFS_CONFIG) begin
        next_s.cfgDelayN = writedata[rtseq_pkg::CFG_DELAY_N_BIT];
        next_s.cfgBodEn  = writedata[rtseq_pkg::CFG_BOD_EN_BIT];
        next_s.cfgMode   = rtseq_pkg::rtseq_osc_mode_t'(
          writedata[rtseq_pkg::CFG_MODE_LSB +: 2]);
      end
    end

    // Sequencer proper
    unique case (s.st)
      rtseq_pkg::ST_DELAY: begin
        if (s.cfgBodEn && supLow) begin
          next_s.st     = rtseq_pkg::ST_BROWNOUT; // RULE8
          next_s.dlyCnt = '0;
        end else if (!delayOn) begin
          leaveDelay = 1'b1; // RULE2
        end else if (slowTick) begin
          if (s.dlyCnt == DW'(DELAY_TICKS - 1)) begin
            leaveDelay = 1'b1; // RULE1
          end else begin
            next_s.dlyCnt = s.dlyCnt + DW'(1);
          end
        end
      end
      rtseq_pkg::ST_SETTLE, rtseq_pkg::ST_WAKE: begin
        if (oscEdge) begin
          if (s.setCnt == SW'(SETTLE_COUNT - 1)) begin
            if (s.st == rtseq_pkg::ST_SETTLE) begin
              goRun = 1'b1; // RULE10
            end else begin
              next_s.st = rtseq_pkg::ST_RUN;
              next_s.pcLoad    = s.wakeVec; // RULE15
              next_s.pcValue   = rtseq_pkg::PC_IRQ_VEC;
              next_s.pcAdvance = ~s.wakeVec;
            end
          end else begin
            next_s.setCnt = s.setCnt + SW'(1); // RULE3
          end
        end
      end
      rtseq_pkg::ST_BROWNOUT: begin
        if (!supLow) begin
          next_s.st     = rtseq_pkg::ST_DELAY; // RULE7
          next_s.dlyCnt = '0;
        end
      end
      rtseq_pkg::ST_RUN: begin
        if (watchdogTimeout) begin
          dogRst = ~clrFall;
        end else if (sleepEnter) begin
          next_s.st             = rtseq_pkg::ST_SLEEP;
          next_s.timeoutFlag    = 1'b1;
          next_s.sleepEntryFlag = 1'b0;
        end else if (clearWatchdog) begin
          next_s.timeoutFlag    = 1'b1;
          next_s.sleepEntryFlag = 1'b1;
        end
      end
      rtseq_pkg::ST_SLEEP: begin
        // Wake-ups keep registers; only flags and the PC move
        if (watchdogTimeout || wakeIrq) begin
          next_s.timeoutFlag    = ~watchdogTimeout; // RULE14 RULE18
          next_s.sleepEntryFlag = 1'b0;
          next_s.wakeVec        = ~watchdogTimeout & globalIrqEnable;
          next_s.setCnt         = '0;
          if (isCrystal) begin
            next_s.st = rtseq_pkg::ST_WAKE; // RULE4
          end else begin
            next_s.st        = rtseq_pkg::ST_RUN;
            next_s.pcLoad    = ~watchdogTimeout & globalIrqEnable; // RULE15
            next_s.pcValue   = rtseq_pkg::PC_IRQ_VEC;
            next_s.pcAdvance = watchdogTimeout | ~globalIrqEnable;
          end
        end
      end
      default: begin
        next_s.st = rtseq_pkg::ST_DELAY;
      end
    endcase

    // Crystal modes settle after the delay, resistor-cap runs
    if (leaveDelay) begin
      if (isCrystal) begin
        next_s.st     = rtseq_pkg::ST_SETTLE; // RULE4 RULE5
        next_s.setCnt = '0;
      end else begin
        goRun = 1'b1; // RULE5
      end
    end
    if (goRun) begin
      next_s.st      = rtseq_pkg::ST_RUN;
      next_s.pcLoad  = 1'b1;
      next_s.pcValue = rtseq_pkg::PC_RESET_VEC;
    end

    // Watchdog reset never touches the pin, only the core
    if (dogRst) begin
      next_s.timeoutFlag    = 1'b0; // RULE14 RULE17
      next_s.sleepEntryFlag = 1'b1;
      next_s.page    = rtseq_pkg::PAGE_RESET;
      next_s.pcLoad  = 1'b1;
      next_s.pcValue = rtseq_pkg::PC_RESET_VEC; // RULE15
    end

    // Master clear outside the power-up delays
    if (clrFall && (s.st == rtseq_pkg::ST_RUN || s.st == rtseq_pkg::ST_SLEEP
                     || s.st == rtseq_pkg::ST_WAKE)) begin
      if (s.st != rtseq_pkg::ST_RUN) begin
        next_s.timeoutFlag    = 1'b1; // RULE14
        next_s.sleepEntryFlag = 1'b0;
      end
      next_s.st      = rtseq_pkg::ST_RUN;
      next_s.page    = rtseq_pkg::PAGE_RESET;
      next_s.pcLoad  = 1'b1;
      next_s.pcValue = rtseq_pkg::PC_RESET_VEC; // RULE15
      next_s.pcAdvance = 1'b0;
    end

    // Brown-out overrides everything, including a bus write
    if (bodTrip && s.st != rtseq_pkg::ST_BROWNOUT) begin
      next_s.st             = rtseq_pkg::ST_BROWNOUT;
      next_s.dlyCnt         = '0;
      next_s.timeoutFlag    = 1'b1; // RULE14 RULE16
      next_s.sleepEntryFlag = 1'b1;
      next_s.page           = rtseq_pkg::PAGE_RESET;
      next_s.pwrStatus[rtseq_pkg::PS_BROWNOUT_N_BIT] = 1'b0; // RULE12
      next_s.pcLoad         = 1'b0;
      next_s.pcAdvance      = 1'b0;
    end

    // Master clear pin held low keeps the core in reset
    next_s.coreResetN = (next_s.st == rtseq_pkg::ST_RUN
                         || next_s.st == rtseq_pkg::ST_SLEEP
                         || next_s.st == rtseq_pkg::ST_WAKE)
                        && !next_s.clrLow && !dogRst; // RULE11
    next_s.coreRun = next_s.coreResetN && (next_s.st == rtseq_pkg::ST_RUN);
  end

  // Raw power-on clears counters and records the cause
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= REG_RESET; // RULE13 RULE16 RULE20
    end else begin
      s <= next_s;
    end
  end

  assign readdata    = s.readdata;
  assign waitrequest = s.waitrequest;
  assign coreResetN  = s.coreResetN;
  assign coreRun     = s.coreRun;
  assign pcLoad      = s.pcLoad;
  assign pcValue     = s.pcValue;
  assign pcAdvance   = s.pcAdvance;
  assign statusUpper = {s.page, s.timeoutFlag, s.sleepEntryFlag};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_delay_holds_core: // RULE1
    assert property (s.st == rtseq_pkg::ST_DELAY |-> !coreResetN)
    else $error("core released while the power-up delay runs");

  a_settle_full_count: // RULE3
    assert property ((s.st == rtseq_pkg::ST_SETTLE) ##1 (s.st == rtseq_pkg::ST_RUN)
                     |-> $past(s.setCnt) == SW'(SETTLE_COUNT - 1) && pcLoad)
    else $error("settle count ended early or without a reset load");

  a_settle_crystal_only: // RULE4
    assert property (s.st != rtseq_pkg::ST_SETTLE && next_s.st == rtseq_pkg::ST_SETTLE
                     |-> isCrystal)
    else $error("settle count entered in resistor-cap mode");

  a_brownout_filter: // RULE6
    assert property (s.st == rtseq_pkg::ST_RUN ##1 s.st == rtseq_pkg::ST_BROWNOUT
                     |-> $past(s.bodCnt) == BW'(BROWNOUT_CYCLES - 1))
    else $error("brown-out taken before the minimum duration");

  a_brownout_redelay: // RULE7
    assert property (s.st == rtseq_pkg::ST_BROWNOUT && !supLow
                     |=> s.st == rtseq_pkg::ST_DELAY && s.dlyCnt == '0)
    else $error("no fresh delay after supply recovery");

  a_delay_restart: // RULE8
    assert property (s.st == rtseq_pkg::ST_DELAY && s.cfgBodEn && supLow
                     |=> s.st == rtseq_pkg::ST_BROWNOUT ##1 !coreResetN)
    else $error("supply-low during delay did not restart");

  a_brownout_flag: // RULE12
    assert property (bodTrip && s.st != rtseq_pkg::ST_BROWNOUT
                     |=> !s.pwrStatus[rtseq_pkg::PS_BROWNOUT_N_BIT]
                         && statusUpper == 5'h03)
    else $error("brown-out did not clear its flag");

  a_watchdog_flags: // RULE14
    assert property (dogRst |=> statusUpper[1:0] == 2'h1 && pcLoad && !coreResetN)
    else $error("watchdog reset flags or load wrong");

  a_clear_glitch: // RULE17
    assert property (!s.clrLow && next_s.clrLow
                     |-> s.mcfCnt == MW'(CLEAR_CYCLES - 1) && !clrPinN)
    else $error("master clear taken without full filter time");

endmodule : rtseq_sequencer

// *** src/rtseq_sync.sv ***
/*
  Two-stage level synchroniser for a group of asynchronous inputs.
  Assumes the inputs are levels that stay put for several core clocks.
*/
`timescale 1ns/1ps
module rtseq_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } rtseq_sync_t;

  rtseq_sync_t s;
  rtseq_sync_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s.meta   = asyncIn;
    next_s.stable = s.meta;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.stable;

endmodule : rtseq_sync
